/* core/lps_pkg.sv */
// Purpose: constants for the lane power and status register slice
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are byte addresses of the register port
package lps_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam logic [7:0]  OFF_STATUS      = 8'h20;
	localparam logic [7:0]  OFF_LANE_CTRL   = 8'h30;
	localparam logic [7:0]  OFF_CLK_DRIVE   = 8'h31;
	localparam logic [7:0]  OFF_D0_DRIVE    = 8'h32;
	localparam logic [7:0]  OFF_D1_DRIVE    = 8'h33;
	localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h40;
	localparam logic [7:0]  OFF_IRQ_MASK    = 8'h41;
	localparam int          ST_PDOWN_BIT    = 7;
	localparam int          ST_STBY_BIT     = 6;
	localparam int          ST_ABSENT_BIT   = 5;
	localparam int          RATE_HI         = 7;
	localparam int          RATE_LO         = 6;
	localparam int          EN_CLK_BIT      = 5;
	localparam int          EN_D0_BIT       = 4;
	localparam int          EN_D1_BIT       = 3;
	localparam int          EN_D2_BIT       = 2;
	localparam int          SWING_HI        = 7;
	localparam int          SWING_LO        = 5;
	localparam int          PRE_HI          = 4;
	localparam int          PRE_LO          = 3;
	localparam logic [7:0]  LANE_CTRL_RST   = 8'h3C;
	localparam logic [7:0]  DRIVE_RST       = 8'h00;
	localparam logic [7:0]  LANE_CTRL_WMASK = 8'hFC;
	localparam logic [7:0]  DRIVE_WMASK     = 8'hFF;
	localparam logic [7:0]  PRE_FIELD_MASK  = 8'h18;
	localparam logic [2:0]  IRQ_RST         = 3'h0;
	localparam logic [1:0]  RATE_5G4        = 2'h0;
	localparam logic [1:0]  RATE_2G7        = 2'h1;
	localparam logic [1:0]  RATE_1G62       = 2'h2;
	localparam logic [1:0]  PRE_NONE        = 2'h0;
	localparam logic [1:0]  PRE_3DB5        = 2'h1;
	localparam logic [1:0]  PRE_6DB         = 2'h2;
	localparam logic [2:0]  SWING_NOMINAL   = 3'h0;
endpackage

/* core/lps_lane_sel.sv */
// Purpose: picks per-lane or global drive codes for one lane
// Assumes: codes are raw register fields
// Notes: purely combinational
`timescale 1ns/100ps
module lps_lane_sel
(
	input  wire logic [2:0] lane_swing,
	input  wire logic [1:0] lane_pre,
	input  wire logic [2:0] glob_swing,
	input  wire logic [1:0] glob_pre,
	input  wire logic       indiv_en,
	input  wire logic       pre_block,
	output logic      [2:0] swing,
	output logic      [1:0] pre
);
	always_comb
	begin
		swing = indiv_en ? lane_swing : glob_swing; // [RULE8]
		pre   = indiv_en ? lane_pre : glob_pre; // [RULE8]
		if (pre_block)
		begin
			pre = lps_pkg::PRE_NONE; // [RULE10]
		end
	end
endmodule

/* core/lps_regs.sv */
// Purpose: power status and lane control register slice of a link redriver
// Assumes: one clock, synchronous inputs, strobes never both high
// Notes: lane outputs are the codes actually applied to the drivers
// Notes on behaviour
// [RULE1] status bit 7 reads one in power-down, zero otherwise; read only
// [RULE2] status bit 6 reads one in standby, zero otherwise; hardware updated
// [RULE3] status bit 5 reads one when no link clock is detected
// [RULE4] lane control bits 7:6 pick rate, 00=5.4G reset, 01=2.7G, 10=1.62G
// [RULE5] lane control bits 5..2 enable clock, d0, d1, d2 lanes; reset one
// [RULE6] rate, enables and drive codes apply only with displayport mode enabled
// [RULE7] swing field bits 7:5, reset 000, per clock, d0 and d1 lanes
// [RULE8] per-lane codes apply only with individual control; else global codes
// [RULE9] pre-emphasis field bits 4:3, reset 00: none, 3.5 dB, 6 dB
// [RULE10] non-displayport mode without swap: clock pre-emphasis writes ignored, none applied
// [RULE11] software avoids reserved codes and writes zero to reserved bits
`timescale 1ns/100ps
module lps_regs
#(
	parameter int ADDR_W = lps_pkg::ADDR_W
)
(
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic              power_down,
	input  wire logic              standby,
	input  wire logic              clock_detected,
	input  wire logic              displayport_operation_enable,
	input  wire logic              indiv_lane_enable,
	input  wire logic              lane_swap,
	input  wire logic [2:0]        glob_clk_swing,
	input  wire logic [2:0]        glob_data_swing,
	input  wire logic [1:0]        glob_pre,
	output logic      [1:0]        link_rate,
	output logic      [3:0]        lane_enable,
	output logic      [2:0]        clk_swing,
	output logic      [1:0]        clk_pre,
	output logic      [2:0]        d0_swing,
	output logic      [1:0]        d0_pre,
	output logic      [2:0]        d1_swing,
	output logic      [1:0]        d1_pre,
	output logic                   irq
);
	typedef struct packed {
		logic [7:0] lane_ctrl;
		logic [7:0] clk_drv;
		logic [7:0] d0_drv;
		logic [7:0] d1_drv;
		logic [2:0] irq_st;
		logic [2:0] irq_mask;
		logic [2:0] st_prev;
		logic [7:0] rdata;
	} lps_state_type;

	lps_state_type st_q;
	lps_state_type st_d;
	logic [7:0]    status;
	logic          dp_on;
	logic          clk_pre_lock;
	logic [2:0]    s_clk;
	logic [2:0]    s_d0;
	logic [2:0]    s_d1;
	logic [1:0]    p_clk;
	logic [1:0]    p_d0;
	logic [1:0]    p_d1;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] wm);
		merge = (old & ~wm) | (wd & wm);
	endfunction

	assign dp_on        = displayport_operation_enable;
	assign clk_pre_lock = ~dp_on & ~lane_swap;

	always_comb
	begin
		status                         = 8'h00;
		status[lps_pkg::ST_PDOWN_BIT]  = power_down; // [RULE1]
		status[lps_pkg::ST_STBY_BIT]   = standby; // [RULE2]
		status[lps_pkg::ST_ABSENT_BIT] = ~clock_detected; // [RULE3]
	end

	always_comb
	begin
		st_d         = st_q;
		st_d.st_prev = status[7:5];
		if (reg_wr)
		begin
			case (reg_addr)
				lps_pkg::OFF_LANE_CTRL:
					st_d.lane_ctrl = merge(st_q.lane_ctrl, reg_wdata,
						lps_pkg::LANE_CTRL_WMASK); // [RULE4] [RULE5]
				lps_pkg::OFF_CLK_DRIVE:
					st_d.clk_drv = merge(st_q.clk_drv, reg_wdata, clk_pre_lock ?
						(lps_pkg::DRIVE_WMASK & ~lps_pkg::PRE_FIELD_MASK) :
						lps_pkg::DRIVE_WMASK); // [RULE10] [RULE7] [RULE9]
				lps_pkg::OFF_D0_DRIVE:
					st_d.d0_drv = reg_wdata; // [RULE7] [RULE9]
				lps_pkg::OFF_D1_DRIVE:
					st_d.d1_drv = reg_wdata; // [RULE7] [RULE9]
				lps_pkg::OFF_IRQ_MASK:
					st_d.irq_mask = reg_wdata[7:5];
				default:
					st_d.irq_mask = st_q.irq_mask;
			endcase
		end
		// write-one-to-clear, but a new edge in the same cycle wins
		if (reg_wr && reg_addr == lps_pkg::OFF_IRQ_STATUS)
		begin
			st_d.irq_st = st_q.irq_st & ~reg_wdata[7:5];
		end
		st_d.irq_st = st_d.irq_st | (status[7:5] ^ st_q.st_prev);
		st_d.rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				lps_pkg::OFF_STATUS:     st_d.rdata = status; // [RULE1] [RULE2] [RULE3]
				lps_pkg::OFF_LANE_CTRL:  st_d.rdata = st_q.lane_ctrl;
				lps_pkg::OFF_CLK_DRIVE:  st_d.rdata = st_q.clk_drv;
				lps_pkg::OFF_D0_DRIVE:   st_d.rdata = st_q.d0_drv;
				lps_pkg::OFF_D1_DRIVE:   st_d.rdata = st_q.d1_drv;
				lps_pkg::OFF_IRQ_STATUS: st_d.rdata = {st_q.irq_st, 5'h00};
				lps_pkg::OFF_IRQ_MASK:   st_d.rdata = {st_q.irq_mask, 5'h00};
				default:                 st_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q.lane_ctrl <= lps_pkg::LANE_CTRL_RST;
			st_q.clk_drv   <= lps_pkg::DRIVE_RST;
			st_q.d0_drv    <= lps_pkg::DRIVE_RST;
			st_q.d1_drv    <= lps_pkg::DRIVE_RST;
			st_q.irq_st    <= lps_pkg::IRQ_RST;
			st_q.irq_mask  <= lps_pkg::IRQ_RST;
			st_q.st_prev   <= 3'h0;
			st_q.rdata     <= 8'h00;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	lps_lane_sel u_clk
	(
		.lane_swing (st_q.clk_drv[lps_pkg::SWING_HI:lps_pkg::SWING_LO]),
		.lane_pre   (st_q.clk_drv[lps_pkg::PRE_HI:lps_pkg::PRE_LO]),
		.glob_swing (glob_clk_swing),
		.glob_pre   (glob_pre),
		.indiv_en   (indiv_lane_enable),
		.pre_block  (clk_pre_lock),
		.swing      (s_clk),
		.pre        (p_clk)
	);

	lps_lane_sel u_d0
	(
		.lane_swing (st_q.d0_drv[lps_pkg::SWING_HI:lps_pkg::SWING_LO]),
		.lane_pre   (st_q.d0_drv[lps_pkg::PRE_HI:lps_pkg::PRE_LO]),
		.glob_swing (glob_data_swing),
		.glob_pre   (glob_pre),
		.indiv_en   (indiv_lane_enable),
		.pre_block  (1'b0),
		.swing      (s_d0),
		.pre        (p_d0)
	);

	lps_lane_sel u_d1
	(
		.lane_swing (st_q.d1_drv[lps_pkg::SWING_HI:lps_pkg::SWING_LO]),
		.lane_pre   (st_q.d1_drv[lps_pkg::PRE_HI:lps_pkg::PRE_LO]),
		.glob_swing (glob_data_swing),
		.glob_pre   (glob_pre),
		.indiv_en   (indiv_lane_enable),
		.pre_block  (1'b0),
		.swing      (s_d1),
		.pre        (p_d1)
	);

	// outside displayport mode the link keeps full rate, all lanes, global drive except no clock pre-emphasis without swap
	always_comb
	begin
		link_rate   = dp_on ? st_q.lane_ctrl[lps_pkg::RATE_HI:lps_pkg::RATE_LO] :
			lps_pkg::RATE_5G4; // [RULE6] [RULE4]
		lane_enable = dp_on ? st_q.lane_ctrl[lps_pkg::EN_CLK_BIT:lps_pkg::EN_D2_BIT] :
			4'hF; // [RULE6] [RULE5]
		clk_swing   = dp_on ? s_clk : glob_clk_swing; // [RULE6]
		d0_swing    = dp_on ? s_d0 : glob_data_swing; // [RULE6]
		d1_swing    = dp_on ? s_d1 : glob_data_swing; // [RULE6]
		clk_pre     = dp_on ? p_clk : (clk_pre_lock ? lps_pkg::PRE_NONE : glob_pre); // [RULE10]
		d0_pre      = dp_on ? p_d0 : glob_pre; // [RULE6]
		d1_pre      = dp_on ? p_d1 : glob_pre; // [RULE6]
	end

	assign reg_rdata = st_q.rdata;
	assign irq       = |(st_q.irq_st & st_q.irq_mask);
endmodule

/* tb/lps_regs_monitor.sv */
// Purpose: concurrent checks on the lane power status register slice
// Assumes: bound to lps_regs, single clock domain
// Notes: status bits are live, so reads compare against the strobe cycle
`timescale 1ns/100ps
module lps_regs_monitor
(
	input wire logic       clk_sys,
	input wire logic       nrst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       power_down,
	input wire logic       standby,
	input wire logic       clock_detected,
	input wire logic       displayport_operation_enable,
	input wire logic       indiv_lane_enable,
	input wire logic       lane_swap,
	input wire logic [1:0] glob_pre,
	input wire logic [1:0] link_rate,
	input wire logic [3:0] lane_enable,
	input wire logic [1:0] clk_pre,
	input wire logic [1:0] d0_pre,
	input wire logic [1:0] d1_pre,
	input wire logic       irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic st_rd;
	logic dp;
	assign st_rd = reg_rd && reg_addr == 8'h20;
	assign dp = displayport_operation_enable;
	pdown_status_a: assert property (st_rd |=> reg_rdata[7] == $past(power_down))
		else $error("power-down status bit wrong");
	stby_status_a: assert property (st_rd |=> reg_rdata[6] == $past(standby))
		else $error("standby status bit wrong");
	absent_flag_a: assert property (st_rd |=> reg_rdata[5] == !$past(clock_detected))
		else $error("signal absent bit wrong");
	status_rsvd_a: assert property (st_rd |=> reg_rdata[4:0] == 5'h0)
		else $error("status reserved bits not zero");
	ctrl_rsvd_a: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[1:0] == 2'h0)
		else $error("lane control reserved bits not zero");
	mode_off_a: assert property (!dp |-> link_rate == 2'h0 && lane_enable == 4'hF)
		else $error("lane settings applied with mode off");
	global_pre_a: assert property (!indiv_lane_enable |-> d0_pre == glob_pre && d1_pre == glob_pre)
		else $error("per-lane pre-emphasis used without lane control");
	clk_pre_off_a: assert property (!dp && !lane_swap |-> clk_pre == 2'h0)
		else $error("clock lane pre-emphasis applied");
	cover property (st_rd);
	cover property (!dp && !lane_swap);
	cover property (irq);
endmodule
bind lps_regs lps_regs_monitor i_mon (.*);

/* tb/lps_regs_tb.sv */
// Purpose: directed register tests of the lane power status slice
// Assumes: reads answer one cycle after the strobe
// Notes: global drive codes held constant to keep the run short
`timescale 1ns/100ps
module lps_regs_tb;
	logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic power_down = 1'b0, standby = 1'b0, clock_detected = 1'b1;
	logic dp = 1'b1, indiv = 1'b1, lane_swap = 1'b0;
	logic [1:0] link_rate, clk_pre, d0_pre, d1_pre;
	logic [2:0] clk_swing, d0_swing, d1_swing;
	logic [3:0] lane_enable;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	lps_regs i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down(power_down),
		.standby(standby), .clock_detected(clock_detected), .displayport_operation_enable(dp),
		.indiv_lane_enable(indiv), .lane_swap(lane_swap), .glob_clk_swing(3'h3),
		.glob_data_swing(3'h6), .glob_pre(2'h1), .link_rate(link_rate),
		.lane_enable(lane_enable), .clk_swing(clk_swing), .clk_pre(clk_pre),
		.d0_swing(d0_swing), .d0_pre(d0_pre), .d1_swing(d1_swing), .d1_pre(d1_pre), .irq(irq));
	initial
	begin
		forever #10 clk_sys = ~clk_sys;
	end
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	task ck(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			$display("Error t=%0t got %h exp %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		ck(reg_rdata, e);
	endtask
	// levels change at the edge so that sampled and combinational views agree
	task set(input logic pd, input logic sb, input logic cd, input logic m, input logic il);
		@(posedge clk_sys);
		{power_down, standby, clock_detected, dp, indiv} <= {pd, sb, cd, m, il};
		#1;
	endtask
	initial
	begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(8'h30, 8'h3C);
		rd(8'h31, 8'h00);
		rd(8'h33, 8'h00);
		rd(8'h55, 8'h00);
		$display("reset values done");
		set(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		wr(8'h20, 8'h00);
		rd(8'h20, 8'hA0);
		set(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		rd(8'h20, 8'h40);
		$display("status done");
		// stimulus keeps clear of reserved rate codes; one clock drive write uses pre-emphasis code 11 while it is locked
		wr(8'h30, 8'h80);
		ck(8'(link_rate), 8'h02);
		wr(8'h30, 8'h53);
		ck(8'(lane_enable), 8'h04);
		rd(8'h30, 8'h50);
		wr(8'h31, 8'hA8);
		wr(8'h32, 8'h50);
		ck({clk_swing, 3'h0, clk_pre}, 8'hA1);
		ck({d0_swing, 3'h0, d0_pre}, 8'h42);
		set(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		ck({d0_swing, clk_swing, d1_pre}, 8'hCD);
		set(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		ck({link_rate, lane_enable}, 8'h0F);
		wr(8'h31, 8'h18);
		rd(8'h31, 8'h08);
		ck(8'(clk_pre), 8'h00);
		@(posedge clk_sys);
		lane_swap <= 1'b1;
		#1;
		ck(8'(clk_pre), 8'h01);
		wr(8'h31, 8'h10);
		rd(8'h31, 8'h10);
		wr(8'h33, 8'hE8);
		set(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		ck({d1_swing, 3'h0, d1_pre}, 8'hE1);
		$display("lane control done");
		wr(8'h41, 8'hE0);
		wr(8'h40, 8'hE0);
		ck(8'(irq), 8'h00);
		set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		@(posedge clk_sys);
		#1;
		ck(8'(irq), 8'h01);
		wr(8'h41, 8'h00);
		ck(8'(irq), 8'h00);
		rd(8'h40, 8'h80);
		rd(8'h41, 8'h00);
		$display("interrupt done");
		print_verdict();
	end
endmodule
